// *** uhc_pkg.sv ***
// Purpose: shared constants and types for the host command/status register pair
// Assumes: single core clock, synchronous active-low reset
// Notes:   offsets are byte addresses on the controller's memory-space register port
package uhc_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  HOST_CMD_OFFSET = 8'h20;
  localparam logic [7:0]  HOST_STS_OFFSET = 8'h24;

  // command register field positions
  localparam int CMD_RUN_BIT       = 0;
  localparam int CMD_CRESET_BIT    = 1;
  localparam int CMD_PSE_BIT       = 4;
  localparam int CMD_ASE_BIT       = 5;
  localparam int CMD_DOORBELL_BIT  = 6;
  localparam int CMD_LRESET_BIT    = 7;
  localparam int CMD_PCOUNT_LSB    = 8;
  localparam int CMD_PCOUNT_MSB    = 9;
  localparam int CMD_PEN_BIT       = 11;
  localparam int CMD_ITC_LSB       = 16;
  localparam int CMD_ITC_MSB       = 23;

  localparam logic [31:0] HOST_CMD_RESET  = 32'h00080000;
  localparam logic [31:0] HOST_STS_RESET  = 32'h00001000;
  localparam logic [31:0] CMD_USED_MASK   = 32'h00ff0bf3;

  // status register field positions
  localparam int STS_ASS_BIT   = 15;
  localparam int STS_PSS_BIT   = 14;
  localparam int STS_RECL_BIT  = 13;
  localparam int STS_HALT_BIT  = 12;
  localparam int STS_EVT_N     = 6;
  localparam int STS_WRAP_BIT  = 3;

  localparam logic [7:0] ITC_DEFAULT        = 8'h08;
  localparam logic       PARK_EN_DEFAULT    = 1'b1;
  localparam logic [1:0] PARK_COUNT_DEFAULT = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int CRESET_TIME_NS     = 1000;
  localparam int CRESET_CYCLES      = (CRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCHED_LATENCY      = 2;

  typedef struct packed {
    logic [7:0] irq_threshold;
    logic       park_enable;
    logic [1:0] park_count;
    logic       light_reset;
    logic       async_advance_doorbell;
    logic       async_sched_enable;
    logic       periodic_sched_enable;
    logic       controller_reset;
    logic       run_control;
  } uhc_cmd_t;

  localparam uhc_cmd_t CMD_DEFAULT = '{irq_threshold: ITC_DEFAULT, default: '0};

endpackage

// *** uhc_reset_seq.sv ***
// Purpose: times a full controller reset and reports its completion
// Assumes: start is a one-cycle pulse
// Notes:   a start while busy restarts the count
`timescale 1ns/10ps
module uhc_reset_seq
  import uhc_pkg::*;
#(
  parameter int CYCLES = CRESET_CYCLES
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);
  logic [15:0] count;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count    <= 16'h0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (start_in) begin
      count    <= 16'(CYCLES - 1);
      busy_out <= 1'b1;
      done_out <= 1'b0;
    end else if (busy_out && count == 16'h0000) begin
      busy_out <= 1'b0;
      done_out <= 1'b1;
    end else begin
      count    <= busy_out ? count - 16'h0001 : count;
      done_out <= 1'b0;
    end
  end
endmodule

// *** uhc_sched_track.sv ***
// Purpose: real schedule state per schedule, trailing its enable by a fixed latency
// Assumes: state counts only while the controller runs
// Notes:   latency stands in for finishing the current traversal step
`timescale 1ns/10ps
module uhc_sched_track
  import uhc_pkg::*;
#(
  parameter int LATENCY = SCHED_LATENCY
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  input  wire logic run_in,
  output logic      state_out
);
  logic [LATENCY-1:0] pipe;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[LATENCY-2:0], enable_in & run_in};
    end
  end

  assign state_out = pipe[LATENCY-1];
endmodule

// *** uhc_regs.sv ***
// Purpose: host controller command and status registers with their side effects
// Assumes: dword accesses only; core signals are synchronous pulses or levels
// Notes:   read data returns one cycle after the read strobe
`timescale 1ns/10ps
module uhc_regs
  import uhc_pkg::*;
#(
  parameter int RESET_CYCLES = CRESET_CYCLES
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              park_capability_in,
  input  wire logic              async_advance_in,
  input  wire logic              frame_wrap_in,
  input  wire logic              system_error_in,
  input  wire logic              transfer_error_in,
  input  wire logic              port_change_in,
  input  wire logic              transfer_done_in,
  input  wire logic              reclamation_in,
  input  wire logic              core_stopped_in,
  output logic [DATA_W-1:0]      reg_rdata_out,
  output logic                   reg_rvalid_out,
  output logic                   run_control_out,
  output logic                   async_sched_enable_out,
  output logic                   periodic_sched_enable_out,
  output logic                   async_sched_state_out,
  output logic                   periodic_sched_state_out,
  output logic                   park_enable_out,
  output logic [1:0]             park_count_out,
  output logic [7:0]             irq_threshold_out,
  output logic                   controller_reset_out,
  output logic                   light_reset_out,
  output logic                   async_advance_doorbell_out,
  output logic                   halted_flag_out
);
  uhc_cmd_t              cmd;
  logic                  park_init;
  logic                  halted;
  logic [STS_EVT_N-1:0]  evt_flags;
  logic [STS_EVT_N-1:0]  evt_set;
  logic [1:0]            sched_state;
  logic                  creset_busy;
  logic                  creset_done;
  logic                  wr_cmd;
  logic                  wr_sts;
  logic                  full_start;
  logic                  light_start;
  logic                  soft_reset;
  logic                  wr_normal;
  logic                  run_set;
  logic [31:0]           cmd_word;
  logic [31:0]           sts_word;
  logic                  aa_fire;

  assign wr_cmd      = reg_wr_in && reg_addr_in == HOST_CMD_OFFSET;
  assign wr_sts      = reg_wr_in && reg_addr_in == HOST_STS_OFFSET;
  assign full_start  = wr_cmd && reg_wdata_in[CMD_CRESET_BIT];
  assign light_start = wr_cmd && reg_wdata_in[CMD_LRESET_BIT] && !full_start && !creset_busy;
  assign soft_reset  = full_start || light_start;
  // command writes during a full reset are dropped, except a new reset request that restarts it, so the controller comes up clean
  assign wr_normal   = wr_cmd && !soft_reset && !creset_busy;
  assign run_set     = wr_normal && reg_wdata_in[CMD_RUN_BIT];
  assign aa_fire     = cmd.async_advance_doorbell && async_advance_in;

  uhc_reset_seq #(
    .CYCLES(RESET_CYCLES)
  ) u_reset_seq (
    .core_clk_in(core_clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (full_start),
    .busy_out   (creset_busy),
    .done_out   (creset_done)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sched
      uhc_sched_track #(
        .LATENCY(SCHED_LATENCY)
      ) u_track (
        .core_clk_in(core_clk_in),
        .rst_n_in   (rst_n_in),
        .enable_in  (gi == 0 ? cmd.periodic_sched_enable : cmd.async_sched_enable),
        .run_in     (cmd.run_control),
        .state_out  (sched_state[gi])
      );
    end
  endgenerate

  assign periodic_sched_state_out = sched_state[0];
  assign async_sched_state_out    = sched_state[1];

  // park defaults depend on a strap-like level, so they are applied after release
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      park_init <= 1'b1;
    end else begin
      park_init <= soft_reset;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cmd <= CMD_DEFAULT;
    end else begin
      if (soft_reset) begin
        cmd                  <= CMD_DEFAULT;
        cmd.controller_reset <= full_start;
        cmd.light_reset      <= light_start;
      end else begin
        cmd.light_reset <= 1'b0;
        if (creset_done) begin
          cmd.controller_reset <= 1'b0;
        end
        if (wr_normal) begin
          cmd.irq_threshold         <= reg_wdata_in[CMD_ITC_MSB:CMD_ITC_LSB];
          cmd.async_sched_enable    <= reg_wdata_in[CMD_ASE_BIT];
          cmd.periodic_sched_enable <= reg_wdata_in[CMD_PSE_BIT];
          cmd.run_control           <= reg_wdata_in[CMD_RUN_BIT];
        end
        // a fresh ring beats the advance that would clear the old one
        if (wr_normal && reg_wdata_in[CMD_DOORBELL_BIT]) begin
          cmd.async_advance_doorbell <= 1'b1;
        end else if (aa_fire) begin
          cmd.async_advance_doorbell <= 1'b0;
        end
        if (!park_capability_in) begin
          cmd.park_enable <= 1'b0;
          cmd.park_count  <= 2'h0;
        end else if (park_init) begin
          cmd.park_enable <= PARK_EN_DEFAULT;
          cmd.park_count  <= PARK_COUNT_DEFAULT;
        end else if (wr_normal) begin
          cmd.park_enable <= reg_wdata_in[CMD_PEN_BIT];
          cmd.park_count  <= reg_wdata_in[CMD_PCOUNT_MSB:CMD_PCOUNT_LSB];
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      halted <= HOST_STS_RESET[STS_HALT_BIT];
    end else if (run_set) begin
      halted <= 1'b0;
    end else if (!cmd.run_control && core_stopped_in) begin
      halted <= 1'b1;
    end
  end

  // event order: done, transfer error, port change, wrap, system error, async advance
  assign evt_set = {aa_fire, system_error_in, frame_wrap_in,
                    port_change_in, transfer_error_in, transfer_done_in};

  generate
    for (gi = 0; gi < STS_EVT_N; gi++) begin : g_evt
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          evt_flags[gi] <= HOST_STS_RESET[gi];
        end else if (soft_reset) begin
          evt_flags[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_flags[gi] <= 1'b1;
        end else if (wr_sts && reg_wdata_in[gi]) begin
          evt_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    cmd_word = 32'h00000000;
    cmd_word[CMD_ITC_MSB:CMD_ITC_LSB]       = cmd.irq_threshold;
    cmd_word[CMD_PEN_BIT]                   = cmd.park_enable;
    cmd_word[CMD_PCOUNT_MSB:CMD_PCOUNT_LSB] = cmd.park_count;
    cmd_word[CMD_LRESET_BIT]                = cmd.light_reset;
    cmd_word[CMD_DOORBELL_BIT]              = cmd.async_advance_doorbell;
    cmd_word[CMD_ASE_BIT]                   = cmd.async_sched_enable;
    cmd_word[CMD_PSE_BIT]                   = cmd.periodic_sched_enable;
    cmd_word[CMD_CRESET_BIT]                = cmd.controller_reset;
    cmd_word[CMD_RUN_BIT]                   = cmd.run_control;
    cmd_word                                = cmd_word & CMD_USED_MASK;
    sts_word = 32'h00000000;
    sts_word[STS_ASS_BIT]                   = async_sched_state_out;
    sts_word[STS_PSS_BIT]                   = periodic_sched_state_out;
    sts_word[STS_RECL_BIT]                  = reclamation_in;
    sts_word[STS_HALT_BIT]                  = halted;
    sts_word[STS_EVT_N-1:0]                 = evt_flags;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out  <= 32'h00000000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        case (reg_addr_in)
          HOST_CMD_OFFSET: reg_rdata_out <= cmd_word;
          HOST_STS_OFFSET: reg_rdata_out <= sts_word;
          default:         reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  assign run_control_out            = cmd.run_control;
  assign async_sched_enable_out     = cmd.async_sched_enable;
  assign periodic_sched_enable_out  = cmd.periodic_sched_enable;
  assign park_enable_out            = cmd.park_enable;
  assign park_count_out             = cmd.park_count;
  assign irq_threshold_out          = cmd.irq_threshold;
  assign controller_reset_out       = cmd.controller_reset;
  assign light_reset_out            = cmd.light_reset;
  assign async_advance_doorbell_out = cmd.async_advance_doorbell;
  assign halted_flag_out            = halted;

  // checks
  logic [ADDR_W-1:0] rd_addr_q;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rd_addr_q <= 8'h00;
    end else begin
      rd_addr_q <= reg_addr_in;
    end
  end

  // reset bit stands for the counted cycles plus the done cycle
  localparam int CRESET_FALL = RESET_CYCLES + 1;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_full_req;
    wr_cmd && reg_wdata_in[CMD_CRESET_BIT] && !creset_busy;
  endsequence

  sequence s_full_cycle;
    controller_reset_out ##[CRESET_FALL:CRESET_FALL] !controller_reset_out;
  endsequence

  sequence s_light_req;
    light_start;
  endsequence

  AST_RSVD_ZERO: assert property (
    reg_rvalid_out && rd_addr_q == HOST_CMD_OFFSET |-> (reg_rdata_out & 32'hff00f40c) == 32'h0)
    else $error("reserved command bits read nonzero");

  AST_ITC_WRITE: assert property (
    wr_normal |=> irq_threshold_out == $past(reg_wdata_in[CMD_ITC_MSB:CMD_ITC_LSB]))
    else $error("threshold not written");

  AST_PARK_EN: assert property (
    wr_normal && park_capability_in && !park_init
    |=> park_enable_out == $past(reg_wdata_in[CMD_PEN_BIT]))
    else $error("park enable not written");

  AST_PARK_CNT: assert property (
    park_init && park_capability_in && !soft_reset |=> park_count_out == PARK_COUNT_DEFAULT)
    else $error("park count default wrong");

  AST_LIGHT_PULSE: assert property (
    s_light_req |=> light_reset_out ##1 !light_reset_out)
    else $error("light reset not a single pulse");

  AST_DOORBELL: assert property (
    aa_fire && !soft_reset && !wr_sts |=> evt_flags[5] && !async_advance_doorbell_out
      || $past(wr_normal && reg_wdata_in[CMD_DOORBELL_BIT]))
    else $error("doorbell advance not flagged");

  AST_ASYNC_OFF: assert property (
    !async_sched_enable_out [*3] |-> !async_sched_state_out)
    else $error("async schedule active while disabled");

  AST_PERIODIC_ON: assert property (
    (periodic_sched_enable_out && run_control_out) [*3] |-> periodic_sched_state_out)
    else $error("periodic state does not follow enable");

  AST_FULL_RESET: assert property (
    s_full_req |=> s_full_cycle)
    else $error("controller reset bit did not self clear in time");

  AST_RUN_CLEARED: assert property (
    s_full_req |=> !run_control_out)
    else $error("run control survived controller reset");

  AST_HALT_ZERO: assert property (
    run_control_out |-> !halted_flag_out)
    else $error("halted while running");

  AST_HALT_SET: assert property (
    !run_control_out && core_stopped_in && !run_set |=> halted_flag_out)
    else $error("halted not set after stop");

  AST_WRAP: assert property (
    frame_wrap_in && !soft_reset |=> evt_flags[STS_WRAP_BIT])
    else $error("frame wrap lost");

  AST_PARK_OFF: assert property (
    !park_capability_in |=> !park_enable_out && park_count_out == 2'h0)
    else $error("park fields nonzero without capability");

endmodule

// *** uhc_testbench.sv ***
// Purpose: self-checking bench for the host command/status register pair
// Assumes: full reset shortened to 4 cycles through the design parameter
// Notes:   expected values come from the register layout, never from the design
`timescale 1ns/10ps
module testbench
  import uhc_pkg::*;
;
  localparam int RC = 4;

  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] exp;
  } uhc_tb_row_t;

  logic              core_clk_in;
  logic              rst_n_in;
  logic              reg_wr_in;
  logic              reg_rd_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in;
  logic              park_capability_in;
  logic              async_advance_in;
  logic [4:0]        ev;
  logic              reclamation_in;
  logic              core_stopped_in;
  logic [DATA_W-1:0] reg_rdata_out;
  logic              reg_rvalid_out;
  logic              run_control_out;
  logic              async_sched_enable_out;
  logic              periodic_sched_enable_out;
  logic              async_sched_state_out;
  logic              periodic_sched_state_out;
  logic              park_enable_out;
  logic [1:0]        park_count_out;
  logic [7:0]        irq_threshold_out;
  logic              controller_reset_out;
  logic              light_reset_out;
  logic              async_advance_doorbell_out;
  logic              halted_flag_out;
  int                error_cnt;
  int                num_checks;
  logic [31:0]       d;
  int                n;
  uhc_tb_row_t       rows [6];

  uhc_regs #(.RESET_CYCLES(RC)) dut_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .park_capability_in(park_capability_in), .async_advance_in(async_advance_in),
    .frame_wrap_in(ev[3]), .system_error_in(ev[4]), .transfer_error_in(ev[1]),
    .port_change_in(ev[2]), .transfer_done_in(ev[0]), .reclamation_in(reclamation_in),
    .core_stopped_in(core_stopped_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .run_control_out(run_control_out),
    .async_sched_enable_out(async_sched_enable_out),
    .periodic_sched_enable_out(periodic_sched_enable_out),
    .async_sched_state_out(async_sched_state_out),
    .periodic_sched_state_out(periodic_sched_state_out),
    .park_enable_out(park_enable_out), .park_count_out(park_count_out),
    .irq_threshold_out(irq_threshold_out), .controller_reset_out(controller_reset_out),
    .light_reset_out(light_reset_out),
    .async_advance_doorbell_out(async_advance_doorbell_out),
    .halted_flag_out(halted_flag_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  // bounded wait for the read answer; a missing answer counts as an error and ends the test
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int i;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    v = 'x;
    for (i = 0; i < 4; i++) begin
      #1;
      if (reg_rvalid_out === 1'b1) break;
      @(posedge core_clk_in);
    end
    if (i == 4) begin
      error_cnt++;
      end_of_test();
    end else begin
      v = reg_rdata_out;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask

  task automatic pulse_ev(input int k);
    @(posedge core_clk_in);
    ev[k] <= 1'b1;
    @(posedge core_clk_in);
    ev    <= '0;
  endtask

  task automatic do_reset(input logic cap);
    @(posedge core_clk_in);
    rst_n_in           <= 1'b0;
    park_capability_in <= cap;
    repeat (3) @(posedge core_clk_in);
    rst_n_in           <= 1'b1;
    cyc(1);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    park_capability_in = 1'b1;
    async_advance_in = 1'b0;
    ev = '0;
    reclamation_in = 1'b0;
    core_stopped_in = 1'b0;
    rows[0] = '{8'h20, 32'hff00f40c, 8'h20, 32'h00000000};
    rows[1] = '{8'h20, 32'h00ff0b00, 8'h20, 32'h00ff0b00};
    rows[2] = '{8'h20, 32'h00a50a30, 8'h20, 32'h00a50a30};
    rows[3] = '{8'h28, 32'hffffffff, 8'h28, 32'h00000000};
    rows[4] = '{8'h2c, 32'h00000000, 8'h20, 32'h00a50a30};
    // enables set but stopped: schedule states must stay low
    rows[5] = '{8'h24, 32'hffffffff, 8'h24, 32'h00001000};
    do_reset(1'b1);
    rd(8'h20, d);
    check(d, 32'h00080b00);
    rd(8'h24, d);
    check(d, 32'h00001000);
    foreach (rows[r]) begin
      wr(rows[r].wa, rows[r].wd);
      rd(rows[r].ra, d);
      check(d, rows[r].exp);
    end
    wr(8'h20, 32'h00080031);
    #1;
    check(run_control_out, 1'b1);
    check(halted_flag_out, 1'b0);
    check({async_sched_enable_out, periodic_sched_enable_out}, 2'b11);
    cyc(1);
    check({async_sched_state_out, periodic_sched_state_out}, 2'b00);
    cyc(1);
    check({async_sched_state_out, periodic_sched_state_out}, 2'b11);
    rd(8'h24, d);
    check(d, 32'h0000c000);
    wr(8'h20, 32'h00080011);
    cyc(3);
    check({async_sched_state_out, periodic_sched_state_out}, 2'b01);
    // engine still busy after stop: halted must wait for it
    wr(8'h20, 32'h00080000);
    cyc(2);
    check(halted_flag_out, 1'b0);
    check({async_sched_state_out, periodic_sched_state_out}, 2'b00);
    @(posedge core_clk_in);
    core_stopped_in <= 1'b1;
    cyc(2);
    check(halted_flag_out, 1'b1);
    for (int k = 0; k < 5; k++) begin
      pulse_ev(k);
      rd(8'h24, d);
      check(d, 32'h00001000 | (32'h1 << k));
      wr(8'h24, 32'h1 << k);
      rd(8'h24, d);
      check(d, 32'h00001000);
    end
    wr(8'h20, 32'h00080040);
    #1;
    check(async_advance_doorbell_out, 1'b1);
    cyc(3);
    check(async_advance_doorbell_out, 1'b1);
    @(posedge core_clk_in);
    async_advance_in <= 1'b1;
    @(posedge core_clk_in);
    async_advance_in <= 1'b0;
    #1;
    check(async_advance_doorbell_out, 1'b0);
    rd(8'h24, d);
    check(d, 32'h00001020);
    wr(8'h20, 32'h00330000);
    pulse_ev(3);
    wr(8'h20, 32'h00000080);
    #1;
    check(light_reset_out, 1'b1);
    check(irq_threshold_out, 8'h08);
    cyc(1);
    check(light_reset_out, 1'b0);
    rd(8'h24, d);
    check(d, 32'h00001000);
    pulse_ev(3);
    wr(8'h20, 32'h00000002);
    #1;
    check(controller_reset_out, 1'b1);
    // write landing while the reset runs must be dropped
    wr(8'h20, 32'h00110000);
    #1;
    for (n = 0; n < 20; n++) begin
      if (controller_reset_out !== 1'b1) break;
      cyc(1);
    end
    check(n, RC - 1);
    rd(8'h20, d);
    check(d & ~32'h00000b00, 32'h00080000);
    rd(8'h24, d);
    check(d & 32'h0000003f, 32'h00000000);
    do_reset(1'b0);
    rd(8'h20, d);
    check(d, 32'h00080000);
    wr(8'h20, 32'h00080b00);
    rd(8'h20, d);
    check(d, 32'h00080000);
    check({park_enable_out, park_count_out}, 3'b000);
    end_of_test();
  end
endmodule
